/* verilog/pdm_pkg.sv */
package pdm_pkg;

   // data word and accumulator widths
   localparam int PDM_WORD_W = 24;
   localparam int PDM_EXT_W  = 8;
   localparam int PDM_IMM_W  = 8;

   typedef struct packed {
      logic [PDM_EXT_W-1:0]  ext;
      logic [PDM_WORD_W-1:0] mid;
      logic [PDM_WORD_W-1:0] low;
   } pdm_acc_t;

   // whole register set seen by the rest of the core
   typedef struct packed {
      logic [3:0][PDM_WORD_W-1:0] input_regs;      // x low, x high, y low, y high
      pdm_acc_t [1:0]             accums;          // index 0 = a, 1 = b
      logic [7:0][PDM_WORD_W-1:0] address_registers;
      logic [7:0][PDM_WORD_W-1:0] offset_registers;
      logic [7:0]                 condition_code_register;
   } pdm_regs_t;

   // parallel move categories
   typedef enum logic [3:0] {
      PDM_CAT_NONE   = 4'h0,
      PDM_CAT_IMM    = 4'h1,
      PDM_CAT_REG    = 4'h2,
      PDM_CAT_UPDATE = 4'h3,
      PDM_CAT_XMEM   = 4'h4,
      PDM_CAT_XREG   = 4'h5,
      PDM_CAT_YMEM   = 4'h6,
      PDM_CAT_REGY   = 4'h7,
      PDM_CAT_LONG   = 4'h8,
      PDM_CAT_XY     = 4'h9
   } pdm_cat_t;

   // data bus transfers taken by a category
   localparam logic [1:0] PDM_XFER_NONE = 2'h0;
   localparam logic [1:0] PDM_XFER_ONE  = 2'h1;
   localparam logic [1:0] PDM_XFER_TWO  = 2'h2;

   // instruction field positions
   localparam int PDM_OP_HI     = 7;
   localparam int PDM_OP_LO     = 0;
   localparam int PDM_IMM_HI    = 15;
   localparam int PDM_IMM_LO    = 8;
   localparam int PDM_IDST_HI   = 20;
   localparam int PDM_IDST_LO   = 16;
   localparam int PDM_RSRC_HI   = 17;
   localparam int PDM_RSRC_LO   = 13;
   localparam int PDM_RDST_HI   = 12;
   localparam int PDM_RDST_LO   = 8;
   localparam int PDM_XY_BIT    = 19;
   localparam int PDM_LONG_BIT  = 18;

   // opcode patterns
   localparam logic [7:0]  PDM_OP_ALU_NOP  = 8'h00;
   localparam logic [2:0]  PDM_IMM_PFX     = 3'h1;
   localparam logic [5:0]  PDM_REG_PFX     = 6'h08;
   localparam logic [15:0] PDM_NONE_CODE   = 16'h2000;
   localparam logic [10:0] PDM_UPDATE_PFX  = 11'h102;
   localparam logic [1:0]  PDM_MEM_PFX     = 2'h1;
   localparam logic [3:0]  PDM_LONG_PFX    = 4'h4;
   localparam logic [3:0]  PDM_XREG_PFX    = 4'h1;

   // register select groups (code[4:3]) and sub-codes (code[2:0])
   localparam logic [1:0] PDM_GRP_DATA = 2'h0;
   localparam logic [1:0] PDM_GRP_ACC  = 2'h1;
   localparam logic [1:0] PDM_GRP_ADDR = 2'h2;
   localparam logic [1:0] PDM_GRP_OFFS = 2'h3;
   localparam logic [2:0] PDM_ACC_LOW  = 3'h0;
   localparam logic [2:0] PDM_ACC_EXT  = 3'h2;
   localparam logic [2:0] PDM_ACC_MID  = 3'h4;
   localparam logic [2:0] PDM_ACC_FULL = 3'h6;

   // condition code bit positions and reset value
   localparam int         PDM_CCR_S     = 7;
   localparam int         PDM_CCR_L     = 6;
   localparam logic [7:0] PDM_CCR_RESET = 8'h00;

   // saturation constants for the middle portion
   localparam logic [23:0] PDM_SAT_POS = 24'h7FFFFF;
   localparam logic [23:0] PDM_SAT_NEG = 24'h800000;

endpackage

/* verilog/pdm_top.sv */
// Overview of operation
// - plain move runs as an arithmetic no-op plus a parallel move, no arithmetic result.
// - plain and register moves change only scaling bit 7 and limit bit 6.
// - one arithmetic operation may run alongside up to two X/Y bus transfers.
// - ten parallel move categories are recognised in move-capable instructions.
// - empty move category does no bus transfer and keeps all condition bits.
// - immediate move: bits 23..21 = 001, destination 20..16, value 15..8.
// - immediate into accumulator part, address or offset register: unsigned, low eight bits.
// - immediate into input register or whole accumulator: signed fraction, top eight bits.
// - a register used by the arithmetic part may also be the move source.
// - whole accumulator copy with integer part in use writes saturation into middle.
// - register move copies any listed source register to any listed destination.
`timescale 1ns/1ps
module pdm_top
   import pdm_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  instr_valid,
   input  wire logic [PDM_WORD_W-1:0] instr_word,
   input  wire logic                  alu_wr,
   input  wire logic                  alu_dst_b,
   input  wire pdm_acc_t              alu_value,
   input  wire logic                  alu_ccr_wr,
   input  wire logic [7:0]            alu_ccr,
   output logic                       instr_ready,
   output logic                       alu_nop,
   output pdm_cat_t                   move_cat,
   output logic [1:0]                 bus_xfers,
   output pdm_regs_t                  regs
);

   pdm_regs_t state;
   pdm_regs_t next_state;

   // architectural registers, one flip-flop group per concern
   logic [3:0][PDM_WORD_W-1:0] input_regs;
   pdm_acc_t [1:0]             accums;
   logic [7:0][PDM_WORD_W-1:0] address_registers;
   logic [7:0][PDM_WORD_W-1:0] offset_registers;
   logic [7:0]                 condition_code_register;
   // condition bits after this instruction and what the move adds to them
   logic [7:0]                 next_ccr;
   logic                       move_lim;
   logic                       move_scl;

   // prefix matches of the move field
   logic                       pfx_xy;
   logic                       pfx_mem;
   logic                       pfx_long;
   logic                       pfx_xreg;
   logic                       pfx_short;
   logic                       pfx_none;
   logic                       pfx_update;
   logic                       pfx_reg;

   // the register view handed to the rest of the core
   assign state = {input_regs, accums, address_registers, offset_registers,
                   condition_code_register};

   assign pfx_xy     = instr_word[PDM_WORD_W-1];
   assign pfx_mem    = instr_word[PDM_WORD_W-1 -: $bits(PDM_MEM_PFX)] == PDM_MEM_PFX;
   assign pfx_long   = instr_word[PDM_WORD_W-1 -: $bits(PDM_LONG_PFX)] == PDM_LONG_PFX &&
                       !instr_word[PDM_LONG_BIT];
   assign pfx_xreg   = instr_word[PDM_WORD_W-1 -: $bits(PDM_XREG_PFX)] == PDM_XREG_PFX;
   assign pfx_short  = instr_word[PDM_WORD_W-1 -: $bits(PDM_IMM_PFX)] == PDM_IMM_PFX;
   assign pfx_none   = instr_word[PDM_WORD_W-1 -: $bits(PDM_NONE_CODE)] == PDM_NONE_CODE;
   assign pfx_update = instr_word[PDM_WORD_W-1 -: $bits(PDM_UPDATE_PFX)] == PDM_UPDATE_PFX;
   assign pfx_reg    = instr_word[PDM_WORD_W-1 -: $bits(PDM_REG_PFX)] == PDM_REG_PFX;

   // whole accumulator seen as a bus word: limited when the integer part is in use
   function automatic logic [PDM_WORD_W-1:0] acc_word(input pdm_acc_t a, output logic lim);
      logic in_use;
      in_use = !((a.ext == {PDM_EXT_W{1'b0}} && !a.mid[PDM_WORD_W-1]) ||
                 (a.ext == {PDM_EXT_W{1'b1}} && a.mid[PDM_WORD_W-1]));
      lim = in_use;
      if (in_use) begin
         acc_word = a.ext[PDM_EXT_W-1] ? PDM_SAT_NEG : PDM_SAT_POS;
      end else begin
         acc_word = a.mid;
      end
   endfunction

   function automatic logic [PDM_WORD_W-1:0] read_reg(input pdm_regs_t s, input logic [4:0] c,
                                                       output logic lim, output logic scl);
      pdm_acc_t a;
      a   = s.accums[c[0]];
      lim = 1'b0;
      scl = 1'b0;
      read_reg = '0;
      unique case (c[4:3])
         PDM_GRP_DATA: read_reg = s.input_regs[c[1:0]];
         PDM_GRP_ACC: begin
            unique case ({c[2:1], 1'b0})
               PDM_ACC_LOW: read_reg = a.low;
               PDM_ACC_EXT: read_reg = {{(PDM_WORD_W-PDM_EXT_W){a.ext[PDM_EXT_W-1]}}, a.ext};
               PDM_ACC_MID: read_reg = a.mid;
               default: begin
                  read_reg = acc_word(a, lim);
                  scl = a.mid[PDM_WORD_W-1] ^ a.mid[PDM_WORD_W-2];
               end
            endcase
         end
         PDM_GRP_ADDR: read_reg = s.address_registers[c[2:0]];
         default:      read_reg = s.offset_registers[c[2:0]];
      endcase
   endfunction

   // write a 24-bit value; a whole accumulator takes it as a fraction
   function automatic pdm_regs_t put_reg(input pdm_regs_t s, input logic [4:0] c,
                                         input logic [PDM_WORD_W-1:0] v);
      put_reg = s;
      unique case (c[4:3])
         PDM_GRP_DATA: put_reg.input_regs[c[1:0]] = v;
         PDM_GRP_ACC: begin
            unique case ({c[2:1], 1'b0})
               PDM_ACC_LOW: put_reg.accums[c[0]].low = v;
               PDM_ACC_EXT: put_reg.accums[c[0]].ext = v[PDM_EXT_W-1:0];
               PDM_ACC_MID: put_reg.accums[c[0]].mid = v;
               default: begin
                  put_reg.accums[c[0]].ext = {PDM_EXT_W{v[PDM_WORD_W-1]}};
                  put_reg.accums[c[0]].mid = v;
                  put_reg.accums[c[0]].low = '0;
               end
            endcase
         end
         PDM_GRP_ADDR: put_reg.address_registers[c[2:0]] = v;
         default:      put_reg.offset_registers[c[2:0]] = v;
      endcase
   endfunction

   function automatic logic is_frac_dst(input logic [4:0] c);
      is_frac_dst = (c[4:3] == PDM_GRP_DATA) ||
                    (c[4:3] == PDM_GRP_ACC && {c[2:1], 1'b0} == PDM_ACC_FULL);
   endfunction

   function automatic logic is_valid_reg(input logic [4:0] c);
      is_valid_reg = (c[4:3] != PDM_GRP_DATA) || c[2];
   endfunction

   // category decode
   always_comb begin
      move_cat = PDM_CAT_NONE;
      if (pfx_xy) begin
         move_cat = PDM_CAT_XY;
      end else if (pfx_mem) begin
         if (pfx_long) begin
            move_cat = PDM_CAT_LONG;
         end else begin
            move_cat = instr_word[PDM_XY_BIT] ? PDM_CAT_YMEM : PDM_CAT_XMEM;
         end
      end else if (pfx_xreg) begin
         move_cat = instr_word[PDM_XY_BIT] ? PDM_CAT_REGY : PDM_CAT_XREG;
      end else if (pfx_short) begin
         if (pfx_none) begin
            move_cat = PDM_CAT_NONE;
         end else if (pfx_update) begin
            move_cat = PDM_CAT_UPDATE;
         end else if (pfx_reg) begin
            move_cat = PDM_CAT_REG;
         end else begin
            move_cat = PDM_CAT_IMM;
         end
      end
   end

   // bus transfers taken next to the arithmetic operation
   always_comb begin
      unique case (move_cat)
         PDM_CAT_XMEM, PDM_CAT_YMEM, PDM_CAT_XREG, PDM_CAT_REGY: bus_xfers = PDM_XFER_ONE;
         PDM_CAT_LONG, PDM_CAT_XY:                               bus_xfers = PDM_XFER_TWO;
         default:                                                bus_xfers = PDM_XFER_NONE;
      endcase
   end

   assign instr_ready = 1'b1;
   assign alu_nop     = (instr_word[PDM_OP_HI:PDM_OP_LO] == PDM_OP_ALU_NOP);
   assign regs        = state;

   // move and write-back; all sources come from state, before any write
   always_comb begin
      logic [4:0]            src_c;
      logic [4:0]            dst_c;
      logic [PDM_IMM_W-1:0]  imm;
      logic [PDM_WORD_W-1:0] val;
      logic                  lim;
      logic                  scl;
      pdm_acc_t              sa;
      src_c = instr_word[PDM_RSRC_HI:PDM_RSRC_LO];
      dst_c = instr_word[PDM_RDST_HI:PDM_RDST_LO];
      imm   = instr_word[PDM_IMM_HI:PDM_IMM_LO];
      val   = '0;
      lim   = 1'b0;
      scl   = 1'b0;
      sa    = state.accums[src_c[0]];
      next_state = state;
      if (instr_valid) begin
         unique case (move_cat)
            PDM_CAT_IMM: begin
               dst_c = instr_word[PDM_IDST_HI:PDM_IDST_LO];
               if (is_frac_dst(dst_c)) begin
                  val = {imm, {(PDM_WORD_W-PDM_IMM_W){1'b0}}};
               end else begin
                  val = {{(PDM_WORD_W-PDM_IMM_W){1'b0}}, imm};
               end
               if (is_valid_reg(dst_c)) begin
                  next_state = put_reg(state, dst_c, val);
               end
            end
            PDM_CAT_REG: begin
               if (is_valid_reg(src_c) && is_valid_reg(dst_c)) begin
                  val   = read_reg(state, src_c, lim, scl);
                  if (is_frac_dst(src_c) && src_c[4:3] == PDM_GRP_ACC && is_frac_dst(dst_c) &&
                      dst_c[4:3] == PDM_GRP_ACC) begin
                     if (lim) begin
                        next_state.accums[dst_c[0]].ext = {PDM_EXT_W{sa.ext[PDM_EXT_W-1]}};
                        next_state.accums[dst_c[0]].mid = val;
                        next_state.accums[dst_c[0]].low = '0;
                     end else begin
                        next_state.accums[dst_c[0]] = sa;
                     end
                  end else begin
                     next_state = put_reg(state, dst_c, val);
                  end
               end
            end
            default: ;
         endcase
         // arithmetic write-back lands after the move; it wins on a forbidden overlap
         if (!alu_nop && alu_wr) begin
            next_state.accums[alu_dst_b] = alu_value;
         end
      end
      // what the move hands to the condition bits
      move_lim = lim;
      move_scl = scl;
   end

   // scaling and limit bits are only ever set; the arithmetic unit owns the other six
   always_comb begin
      next_ccr = state.condition_code_register;
      if (instr_valid) begin
         if (!alu_nop && alu_ccr_wr) begin
            next_ccr = alu_ccr;
         end
         next_ccr[PDM_CCR_S] = next_ccr[PDM_CCR_S] | state.condition_code_register[PDM_CCR_S] |
                               move_scl;
         next_ccr[PDM_CCR_L] = next_ccr[PDM_CCR_L] | state.condition_code_register[PDM_CCR_L] |
                               move_lim;
      end
   end

   // input registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         input_regs <= '0;
      end else begin
         input_regs <= next_state.input_regs;
      end
   end

   // accumulators
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         accums <= '0;
      end else begin
         accums <= next_state.accums;
      end
   end

   // address registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         address_registers <= '0;
      end else begin
         address_registers <= next_state.address_registers;
      end
   end

   // offset registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         offset_registers <= '0;
      end else begin
         offset_registers <= next_state.offset_registers;
      end
   end

   // condition code register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         condition_code_register <= PDM_CCR_RESET;
      end else begin
         condition_code_register <= next_ccr;
      end
   end

endmodule

/* dv/pdm_monitor.sv */
`timescale 1ns/1ps
module pdm_monitor
   import pdm_pkg::*;
(
   input wire logic                  sys_clk,
   input wire logic                  resetn,
   input wire logic                  instr_valid,
   input wire logic [PDM_WORD_W-1:0] instr_word,
   input wire logic                  alu_ccr_wr,
   input wire logic                  alu_nop,
   input wire pdm_cat_t              move_cat,
   input wire logic [1:0]            bus_xfers,
   input wire pdm_regs_t             regs
);
   wire logic [7:0] cc = regs.condition_code_register;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_nop_decode: assert property (alu_nop == (instr_word[7:0] == PDM_OP_ALU_NOP))
      else $error("alu_nop wrong");
   a_none_idle: assert property (move_cat == PDM_CAT_NONE |-> bus_xfers == 2'h0)
      else $error("empty move uses bus");
   a_xy_pair: assert property (instr_word[23] |-> move_cat == PDM_CAT_XY && bus_xfers == 2'h2)
      else $error("dual move decode wrong");
   a_none_ccr: assert property (instr_valid && instr_word[23:8] == PDM_NONE_CODE && !alu_ccr_wr |=>
      $stable(cc)) else $error("empty move changed ccr");
   a_nop_hold: assert property (instr_valid && alu_nop && instr_word[23:8] == PDM_NONE_CODE |=>
      $stable(regs)) else $error("no-op changed state");
   a_imm_input: assert property (instr_valid && instr_word[23:16] == 8'h24 |=>
      regs.input_regs[0] == {$past(instr_word[15:8]), 16'h0000}) else $error("signed immediate wrong");
   a_imm_addr: assert property (instr_valid && instr_word[23:19] == 5'h06 |=>
      regs.address_registers[$past(instr_word[18:16])] == {16'h0000, $past(instr_word[15:8])})
      else $error("unsigned immediate wrong");
   a_ccr_low: assert property (instr_valid && alu_nop |=> cc[5:0] == $past(cc[5:0]))
      else $error("move changed low ccr bits");
   a_sl_sticky: assert property ($past(resetn) |-> !$fell(cc[7]) && !$fell(cc[6]))
      else $error("s or l cleared");
   c_imm: cover property (instr_valid && move_cat == PDM_CAT_IMM);
   c_reg: cover property (instr_valid && move_cat == PDM_CAT_REG && !alu_nop);
   c_none: cover property (instr_valid && move_cat == PDM_CAT_NONE && alu_nop);
endmodule
bind pdm_top pdm_monitor pdm_monitor_i (.sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid),
   .instr_word(instr_word), .alu_ccr_wr(alu_ccr_wr), .alu_nop(alu_nop), .move_cat(move_cat),
   .bus_xfers(bus_xfers), .regs(regs));

/* dv/pdm_ctrl_model.sv */
`timescale 1ns/1ps
module pdm_ctrl_model
   import pdm_pkg::*;
(
   output logic                  instr_valid,
   output logic [PDM_WORD_W-1:0] instr_word
);
   initial begin
      instr_valid = 1'h0;
      instr_word  = 24'h000000;
   end
   // an idle slot shows a changing word, never the last one
   task automatic issue(input logic v, input logic [PDM_WORD_W-1:0] w);
      instr_valid = v;
      instr_word  = v ? w : ~instr_word;
   endtask
endmodule

/* dv/pdm_top_tb.sv */
`timescale 1ns/1ps
module pdm_top_tb
   import pdm_pkg::*;
;
   logic                  sys_clk = 1'h0;
   logic                  resetn = 1'h0;
   logic                  instr_valid, alu_wr, alu_dst_b, alu_ccr_wr, instr_ready, alu_nop;
   logic [PDM_WORD_W-1:0] instr_word, w, s;
   logic [7:0]            alu_ccr, op;
   logic [1:0]            bus_xfers, kind;
   logic [4:0]            dst, src;
   logic [31:0]           seed = 32'h5E279B95;
   logic [31:0]           r, q;
   pdm_acc_t              alu_value, a;
   pdm_cat_t              move_cat;
   pdm_regs_t             regs, m;
   int                    failures = 0;
   int                    total_checks = 0;
   always #2 sys_clk = ~sys_clk;
   pdm_ctrl_model pdm_ctrl_model_i (.instr_valid(instr_valid), .instr_word(instr_word));
   pdm_top pdm_top_i (.sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_word(instr_word),
      .alu_wr(alu_wr), .alu_dst_b(alu_dst_b), .alu_value(alu_value), .alu_ccr_wr(alu_ccr_wr), .alu_ccr(alu_ccr),
      .instr_ready(instr_ready), .alu_nop(alu_nop), .move_cat(move_cat), .bus_xfers(bus_xfers), .regs(regs));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string n, input logic [599:0] e, input logic [599:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [23:0] rd(input logic [4:0] c);
      pdm_acc_t x;
      x = m.accums[c[0]];
      case (c[4:3])
         PDM_GRP_DATA: return m.input_regs[c[1:0]];
         PDM_GRP_ADDR: return m.address_registers[c[2:0]];
         PDM_GRP_OFFS: return m.offset_registers[c[2:0]];
         default: return c[2:1] == 2'h0 ? x.low : c[2:1] == 2'h1 ? {{16{x.ext[7]}}, x.ext} :
            c[2:1] == 2'h2 || x.ext == {8{x.mid[23]}} ? x.mid : x.ext[7] ? PDM_SAT_NEG : PDM_SAT_POS;
      endcase
   endfunction
   task automatic wr(input logic [4:0] c, input logic [23:0] v);
      case (c[4:3])
         PDM_GRP_DATA: m.input_regs[c[1:0]] = v;
         PDM_GRP_ADDR: m.address_registers[c[2:0]] = v;
         PDM_GRP_OFFS: m.offset_registers[c[2:0]] = v;
         default: case (c[2:1])
            2'h0: m.accums[c[0]].low = v;
            2'h1: m.accums[c[0]].ext = v[7:0];
            2'h2: m.accums[c[0]].mid = v;
            default: m.accums[c[0]] = {{8{v[23]}}, v, 24'h000000};
         endcase
      endcase
   endtask
   initial begin
      {alu_wr, alu_dst_b, alu_ccr_wr, alu_ccr, alu_value} = 67'h0;
      m = '0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) resetn = 1'h1;
      for (int i = 0; i < 400; i++) begin
         r = xs();
         q = xs();
         kind = i % 50 == 0 ? 2'h0 : r[1:0];
         op = r[2] ? 8'h00 : r[15:8];
         dst = i % 50 == 0 ? 5'h04 : 5'h04 + r[20:16] % 5'h1C;
         src = 5'h04 + q[4:0] % 5'h1C;
         w = kind == 0 ? {3'h1, dst, q[31:24], op} : kind == 1 ? {6'h08, src, dst, op} :
            kind == 2 ? {PDM_NONE_CODE, op} : {1'h1, q[22:8], op};
         {alu_wr, alu_dst_b, alu_ccr_wr} = r[5:3];
         alu_ccr = r[31:24];
         alu_value = {r[23:0], xs()};
         if (kind < 2 && dst[4:3] == PDM_GRP_ACC && dst[0] == alu_dst_b) alu_dst_b = ~dst[0];
         pdm_ctrl_model_i.issue(r[6] | r[7] | i % 50 == 0, w);
         #1;
         if (instr_valid) begin
            chk("alu_nop", op == 8'h00, alu_nop);
            chk("move_cat", kind == 0 ? PDM_CAT_IMM : kind == 1 ? PDM_CAT_REG : kind == 2 ? PDM_CAT_NONE : PDM_CAT_XY,
               move_cat);
            chk("bus_xfers", kind == 3 ? 2'h2 : 2'h0, bus_xfers);
            chk("instr_ready", 1'h1, instr_ready);
            s = rd(src);
            a = m.accums[src[0]];
            if (op != 8'h00 && alu_wr) m.accums[alu_dst_b] = alu_value;
            if (op != 8'h00 && alu_ccr_wr)
               m.condition_code_register = {m.condition_code_register[7:6] | alu_ccr[7:6], alu_ccr[5:0]};
            if (kind == 0) wr(dst, dst[4:3] == PDM_GRP_DATA || dst[4:3] == PDM_GRP_ACC && dst[2:1] == 2'h3 ?
               {q[31:24], 16'h0000} : {16'h0000, q[31:24]});
            if (kind == 1) wr(dst, s);
            if (kind == 1 && src[4:3] == PDM_GRP_ACC && src[2:1] == 2'h3 && dst[4:3] == PDM_GRP_ACC &&
               dst[2:1] == 2'h3 && a.ext == {8{a.mid[23]}}) m.accums[dst[0]] = a;
            if (kind == 1 && src[4:3] == PDM_GRP_ACC && src[2:1] == 2'h3)
               m.condition_code_register[7:6] |= {a.mid[23] ^ a.mid[22], a.ext != {8{a.mid[23]}}};
         end
         @(negedge sys_clk);
         chk("regs", m, regs);
         if (i == 200) begin
            resetn = 1'h0;
            m = '0;
            @(negedge sys_clk);
            resetn = 1'h1;
            chk("regs", m, regs);
         end
      end
      give_verdict();
   end
endmodule
